/* design/eism_monitor.v */
`timescale 1ns/1ps
`include "eism_defs.vh"

// How it works
// - Incremental resolution selectable as 1024, 2048 or 4096 counts per turn.
// - Encoder position kept in a 32-bit signed counter, updated each count.
// - Absolute mode: fixed 2048 per turn, turns and single-turn form 32 bits.
// - With stall check on, compare encoder and motor always; flag beyond 45 deg.
// - Stall reported to host, motor position made invalid, active move halted.
// - Absolute moves refused while position invalid until homed or preset.
// - Three inputs, each with programmable function and active polarity.
// - Home function input is the sensor sought by homing moves.
// - Limit hit while moving that way stops motion; only opposite jog then.
// - Indexer move waits pending until start input activating edge.
// - Start input: every transition latches encoder position.
// - Captured encoder values are returned to the host.
// - Halt input active: stop, keep driver enabled, refuse every move.
// - Halt during move: short windings 300 ms, then set halted flag.
// - Jog-stop edge gives controlled stop only in jog or registration moves.
// - Jog-stop edge latches encoder only during jog or registration move.
// - General purpose inputs affect nothing, state reported to host.
// - LED: green ok, red hot, blink green/red flash result, alternate comm fail.
// - After flash write commands rejected; flash fault holds until power cycle.
// - LED blinks green at init, red three times on absolute encoder error.
module eism_monitor
#(
  parameter SHORT_CYC = `EISM_SHORT_CYC,
  parameter BLINK_CYC = `EISM_BLINK_CYC
)
(
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Configuration
  input  wire        absMode,
  input  wire [1:0]  resSel,
  input  wire        stallEn,
  input  wire [8:0]  inFunc,
  input  wire [2:0]  inPol,
  // Encoder
  input  wire        encA,
  input  wire        encB,
  input  wire [31:0] absPos,
  input  wire        absErr,
  // Field inputs
  input  wire [2:0]  inRaw,
  // Move generator
  input  wire [31:0] motorPos,
  input  wire        moveReq,
  input  wire [2:0]  moveType,
  input  wire        moveDirCw,
  input  wire        moveDone,
  input  wire        presetReq,
  input  wire        homeDone,
  // Device status
  input  wire        initBusy,
  input  wire        overTemp,
  input  wire        flashOk,
  input  wire        flashFail,
  input  wire        commFail,
  // Host-facing outputs
  output reg  [31:0] encPos_r,
  output reg  [31:0] capPos_r,
  output reg         capValid_r,
  output reg         stall_r,
  output reg         posInvalid_r,
  output reg         halted_r,
  output reg  [2:0]  inState_r,
  output wire        cmdAccept,
  output wire        moveStart,
  output reg         moveStop_r,
  output reg         ctrlStop_r,
  output reg         windShort_r,
  output wire        homeSeen,
  output reg  [2:0]  curMove_r,
  output reg         ledGreen_r,
  output reg         ledRed_r
);

  // ------------------------------------------------------------
  // Input conditioning
  // ------------------------------------------------------------
  reg  [2:0] inS1_r, inS2_r, inAct_r;
  wire [2:0] inActNxt = inS2_r ^ inPol;
  wire [2:0] inRise   = inActNxt & ~inAct_r;
  wire [2:0] inChg    = inActNxt ^ inAct_r;

  reg  [2:0] isHome, isCw, isCcw, isStart, isEstop, isJog, isGp;
  integer k;
  always @*
  begin
    for (k = 0; k < 3; k = k + 1)
    begin
      isHome[k]  = inFunc[3*k +: 3] == `EISM_FN_HOME;
      isCw[k]    = inFunc[3*k +: 3] == `EISM_FN_CWLIM;
      isCcw[k]   = inFunc[3*k +: 3] == `EISM_FN_CCWLIM;
      isStart[k] = inFunc[3*k +: 3] == `EISM_FN_START;
      isEstop[k] = inFunc[3*k +: 3] == `EISM_FN_ESTOP;
      isJog[k]   = inFunc[3*k +: 3] == `EISM_FN_JOGSTOP;
      isGp[k]    = inFunc[3*k +: 3] == `EISM_FN_GP;
    end
  end

  wire estopAct  = |(inAct_r & isEstop);
  wire cwAct     = |(inAct_r & isCw);
  wire ccwAct    = |(inAct_r & isCcw);
  wire startRise = |(inRise & isStart);
  wire startChg  = |(inChg & isStart);
  wire jogRise   = |(inRise & isJog);
  assign homeSeen = |(inAct_r & isHome);

  // ------------------------------------------------------------
  // Quadrature decode
  // ------------------------------------------------------------
  reg  [1:0] qS1_r, qS2_r, qPrev_r;
  wire [1:0] qCur  = qS2_r;
  wire       qStep = (qCur != qPrev_r) && ((qCur ^ qPrev_r) != 2'b11);
  wire       qUp   = qPrev_r[0] ^ qCur[1];

  // ------------------------------------------------------------
  // Stall comparison
  // ------------------------------------------------------------
  reg  [31:0] cpt;
  always @*
  begin
    if (absMode)
      cpt = `EISM_ABS_CPT;
    else
    begin
      case (resSel)
        `EISM_RES_1024: cpt = 32'd1024;
        `EISM_RES_2048: cpt = 32'd2048;
        default:        cpt = 32'd4096;
      endcase
    end
  end
  wire [31:0] posErr = encPos_r - motorPos;
  wire [31:0] absErrV = posErr[31] ? (~posErr + 32'd1) : posErr;
  wire        stallHit = stallEn && (absErrV > (cpt >> `EISM_STALL_SHIFT));

  // ------------------------------------------------------------
  // Move acceptance
  // ------------------------------------------------------------
  reg indexPend_r, flashLock_r, limCw_r, limCcw_r, dirCw_r;
  wire moving = curMove_r != `EISM_MV_NONE;
  wire jogLike = (curMove_r == `EISM_MV_JOG) || (curMove_r == `EISM_MV_REG);
  wire reqJog  = moveType == `EISM_MV_JOG;
  wire limBlock = (limCw_r && !(reqJog && !moveDirCw)) ||
                  (limCcw_r && !(reqJog && moveDirCw));
  assign cmdAccept = moveReq && !flashLock_r && !estopAct && !windShort_r && !limBlock &&
                     !(posInvalid_r && moveType == `EISM_MV_ABS);
  // Direction of the running move, not of whatever request is on the bus
  wire limStop = (moving && dirCw_r && cwAct) || (moving && !dirCw_r && ccwAct);
  wire idxFire = indexPend_r && startRise && !estopAct;
  assign moveStart = (cmdAccept && !moving && moveType != `EISM_MV_INDEX) || idxFire;

  reg [31:0] shortCnt_r;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inS1_r <= 3'h0; inS2_r <= 3'h0; inAct_r <= 3'h0; inState_r <= 3'h0;
      qS1_r <= 2'h0; qS2_r <= 2'h0; qPrev_r <= 2'h0;
      encPos_r <= 32'h0; capPos_r <= 32'h0; capValid_r <= 1'b0;
      stall_r <= 1'b0; posInvalid_r <= 1'b0; halted_r <= 1'b0;
      moveStop_r <= 1'b0; ctrlStop_r <= 1'b0; windShort_r <= 1'b0;
      curMove_r <= `EISM_MV_NONE; indexPend_r <= 1'b0; flashLock_r <= 1'b0;
      limCw_r <= 1'b0; limCcw_r <= 1'b0; shortCnt_r <= 32'h0; dirCw_r <= 1'b0;
    end
    else
    begin
      inS1_r <= inRaw; inS2_r <= inS1_r; inAct_r <= inActNxt;
      inState_r <= inAct_r & isGp;
      qS1_r <= {encA, encB}; qS2_r <= qS1_r; qPrev_r <= qCur;
      if (absMode)
        encPos_r <= absPos;
      else if (qStep)
        encPos_r <= qUp ? encPos_r + 32'd1 : encPos_r - 32'd1;
      capValid_r <= 1'b0;
      if (startChg || (jogRise && jogLike))
      begin
        capPos_r <= encPos_r;
        capValid_r <= 1'b1;
      end
      if (flashOk || flashFail)
        flashLock_r <= 1'b1;
      moveStop_r <= 1'b0;
      ctrlStop_r <= 1'b0;
      if (stallHit)
      begin
        stall_r <= 1'b1;
        posInvalid_r <= 1'b1;
      end
      else if (presetReq || homeDone)
      begin
        stall_r <= 1'b0;
        posInvalid_r <= 1'b0;
      end
      if (cmdAccept && moveType == `EISM_MV_INDEX)
        indexPend_r <= 1'b1;
      else if (idxFire || estopAct)
        indexPend_r <= 1'b0;
      if (moveStart)
      begin
        curMove_r <= idxFire ? `EISM_MV_INDEX : moveType;
        dirCw_r <= moveDirCw;
        halted_r <= 1'b0;
        limCw_r <= 1'b0;
        limCcw_r <= 1'b0;
      end
      if (moving && estopAct)
      begin
        curMove_r <= `EISM_MV_NONE;
        moveStop_r <= 1'b1;
        windShort_r <= 1'b1;
        shortCnt_r <= 32'h0;
      end
      else if (moving && (stallHit || limStop))
      begin
        curMove_r <= `EISM_MV_NONE;
        moveStop_r <= 1'b1;
        if (limStop)
        begin
          limCw_r <= dirCw_r;
          limCcw_r <= !dirCw_r;
        end
      end
      else if (jogLike && jogRise)
        ctrlStop_r <= 1'b1;
      else if (moving && moveDone)
        curMove_r <= `EISM_MV_NONE;
      if (windShort_r)
      begin
        if (shortCnt_r == SHORT_CYC - 1)
        begin
          windShort_r <= 1'b0;
          halted_r <= 1'b1;
        end
        else
          shortCnt_r <= shortCnt_r + 32'd1;
      end
    end
  end

  // ------------------------------------------------------------
  // Module status LED
  // ------------------------------------------------------------
  reg [31:0] blkCnt_r;
  reg        phase_r;
  reg [2:0]  redBlinks_r;
  reg        okFlash_r, badFlash_r, absBad_r;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blkCnt_r <= 32'h0; phase_r <= 1'b0; redBlinks_r <= 3'h0;
      okFlash_r <= 1'b0; badFlash_r <= 1'b0; absBad_r <= 1'b0;
      ledGreen_r <= 1'b0; ledRed_r <= 1'b0;
    end
    else
    begin
      if (blkCnt_r == BLINK_CYC - 1)
      begin
        blkCnt_r <= 32'h0;
        phase_r <= ~phase_r;
        if (phase_r && redBlinks_r != 3'h0 && absBad_r)
          redBlinks_r <= redBlinks_r - 3'h1;
      end
      else
        blkCnt_r <= blkCnt_r + 32'd1;
      if (flashOk) okFlash_r <= 1'b1;
      if (flashFail) badFlash_r <= 1'b1;
      if (absErr && absMode && !absBad_r)
      begin
        absBad_r <= 1'b1;
        redBlinks_r <= 3'h3;
      end
      if (absBad_r && redBlinks_r != 3'h0)
      begin
        ledGreen_r <= 1'b0; ledRed_r <= phase_r;
      end
      else if (initBusy)
      begin
        ledGreen_r <= phase_r; ledRed_r <= 1'b0;
      end
      else if (commFail)
      begin
        ledGreen_r <= phase_r; ledRed_r <= ~phase_r;
      end
      else if (badFlash_r)
      begin
        ledGreen_r <= 1'b0; ledRed_r <= phase_r;
      end
      else if (okFlash_r)
      begin
        ledGreen_r <= phase_r; ledRed_r <= 1'b0;
      end
      else if (overTemp)
      begin
        ledGreen_r <= 1'b0; ledRed_r <= 1'b1;
      end
      else
      begin
        ledGreen_r <= 1'b1; ledRed_r <= 1'b0;
      end
    end
  end

endmodule // eism_monitor

/* design/eism_defs.vh */
`ifndef EISM_DEFS_VH
`define EISM_DEFS_VH
// Resolution selects (incremental)
`define EISM_RES_1024      2'd0
`define EISM_RES_2048      2'd1
`define EISM_RES_4096      2'd2
`define EISM_ABS_CPT       32'd2048
// Stall limit: 45 degrees = counts/8
`define EISM_STALL_SHIFT   3
// Input functions
`define EISM_FN_GP         3'd0
`define EISM_FN_HOME       3'd1
`define EISM_FN_CWLIM      3'd2
`define EISM_FN_CCWLIM     3'd3
`define EISM_FN_START      3'd4
`define EISM_FN_ESTOP      3'd5
`define EISM_FN_JOGSTOP    3'd6
// Move types
`define EISM_MV_NONE       3'd0
`define EISM_MV_JOG        3'd1
`define EISM_MV_REG        3'd2
`define EISM_MV_REL        3'd3
`define EISM_MV_ABS        3'd4
`define EISM_MV_HOME       3'd5
`define EISM_MV_INDEX      3'd6
// Timing
`define EISM_CLK_MHZ       125
`define EISM_SHORT_MS      300
`define EISM_SHORT_CYC     (`EISM_SHORT_MS * 1000 * `EISM_CLK_MHZ)
`define EISM_BLINK_CYC     (62 * 1000 * 1000)
// LED states
`define EISM_LED_OFF       2'd0
`define EISM_LED_GREEN     2'd1
`define EISM_LED_RED       2'd2
`endif

/* bench/eism_properties.sv */
`timescale 1ns/1ps
module eism_properties
#(
  parameter SHORT_CYC = 20
)
(
  // Clock, reset, inputs
  input wire        clk_sys,
  input wire        rst_n,
  input wire [8:0]  inFunc,
  input wire [2:0]  moveType,
  input wire        flashOk,
  input wire        flashFail,
  // Outputs
  input wire        cmdAccept,
  input wire        capValid_r,
  input wire        stall_r,
  input wire        posInvalid_r,
  input wire        halted_r,
  input wire [2:0]  inState_r,
  input wire        moveStop_r,
  input wire        windShort_r,
  input wire [2:0]  curMove_r
);
  reg        lock_r;
  reg [31:0] shortCnt_r;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ----
  // Helpers
  // ----
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      lock_r     <= 1'b0;
      shortCnt_r <= 32'h0;
    end
    else
    begin
      lock_r     <= lock_r | flashOk | flashFail;
      shortCnt_r <= windShort_r ? shortCnt_r + 32'h1 : 32'h0;
    end
  a_abs_refused: assert property (posInvalid_r && moveType == 3'h4 |-> !cmdAccept)
    else $error("abs move taken while invalid");
  a_short_refuses: assert property (windShort_r |-> !cmdAccept)
    else $error("move taken while shorted");
  a_short_length: assert property ($fell(windShort_r) |-> shortCnt_r == SHORT_CYC)
    else $error("short length wrong");
  a_halt_after: assert property ($fell(windShort_r) |-> halted_r)
    else $error("halted flag missing");
  a_cap_pulse: assert property (capValid_r |=> !capValid_r)
    else $error("capture pulse too long");
  a_stall_invalid: assert property ($rose(stall_r) |-> ##[0:1] posInvalid_r)
    else $error("stall left position valid");
  a_stall_halts: assert property ($rose(stall_r) && $past(curMove_r) != 3'h0 |-> moveStop_r)
    else $error("stall did not stop move");
  a_gp_masked: assert property (inFunc[2:0] != 3'h0 && $past(inFunc, 4) == inFunc |-> !inState_r[0])
    else $error("non-GP input reported");
  a_flash_lock: assert property (lock_r |-> !cmdAccept)
    else $error("move taken after flash write");
  cover property ($fell(windShort_r));
  cover property ($rose(stall_r));
  cover property (lock_r && moveType != 3'h0);
endmodule // eism_properties

bind eism_monitor eism_properties #(.SHORT_CYC(SHORT_CYC)) u_eism_properties (.*);

/* bench/eism_field_model.sv */
`timescale 1ns/1ps
module eism_field_model
(
  // Clock
  input wire       clk_sys,
  // Encoder phases and contacts
  output reg       encA,
  output reg       encB,
  output reg [2:0] inRaw
);
  reg [1:0] ph_r;
  initial {ph_r, encA, encB, inRaw} = 7'h0;
  // ----
  // Quadrature, A leads B going forward
  // ----
  task step(input logic fwd, input integer n);
    repeat (n)
    begin
      repeat (2) @(posedge clk_sys);
      ph_r = fwd ? ph_r + 2'h1 : ph_r - 2'h1;
      encA <= ph_r[1] ^ ph_r[0];
      encB <= ph_r[1];
    end
  endtask
  // Contacts only move on an edge
  task press(input integer i, input logic v);
    @(posedge clk_sys);
    inRaw[i] <= v;
  endtask
endmodule // eism_field_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys, rst_n, absMode, stallEn, absErr, moveReq, moveDirCw, moveDone;
  logic        presetReq, homeDone, initBusy, overTemp, flashOk, flashFail, commFail;
  logic        encA, encB, capValid_r, stall_r, posInvalid_r, halted_r, cmdAccept;
  logic        moveStart, moveStop_r, ctrlStop_r, windShort_r, homeSeen, ledGreen_r;
  logic        ledRed_r, acc;
  logic [1:0]  resSel;
  logic [2:0]  inPol, inRaw, moveType, inState_r, curMove_r;
  logic [3:0]  seen;
  // Row: dir, type, accepted, running type
  logic [7:0]  rows [5] = '{8'h99, 8'h2a, 8'hbb, 8'h4c, 8'hdd};
  logic [8:0]  inFunc;
  logic [31:0] absPos, motorPos, encPos_r, capPos_r;
  integer      err_count = 0;
  integer      cmp_count = 0;
  integer      i;
  eism_monitor #(.SHORT_CYC(20), .BLINK_CYC(8)) u_eism_monitor (.*);
  eism_field_model u_eism_field_model (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ----
  // Tasks
  // ----
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task req(input logic [2:0] t, input logic d);
    @(posedge clk_sys);
    {moveReq, moveType, moveDirCw} <= {1'b1, t, d};
    @(negedge clk_sys) acc = cmdAccept;
    @(posedge clk_sys) moveReq <= 1'b0;
  endtask
  task mvDone;
    @(posedge clk_sys) moveDone <= 1'b1;
    @(posedge clk_sys) moveDone <= 1'b0;
  endtask
  // Collects pulses, which stand one cycle only
  task win(input integer n);
    seen = 4'h0;
    repeat (n) @(negedge clk_sys) seen = seen | {capValid_r, moveStart, ctrlStop_r, moveStop_r};
  endtask
  initial
  begin
    #100000;
    err_count++;
    tally_and_finish;
  end
  // ----
  // Sequence
  // ----
  initial
  begin
    {absMode, stallEn, absErr, moveReq, moveDirCw, moveDone, presetReq, homeDone} = 8'h0;
    {initBusy, overTemp, flashOk, flashFail, commFail, resSel, inPol, moveType} = 13'h0;
    {inFunc, absPos, motorPos} = 73'h0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    chk("reset", encPos_r | {stall_r, posInvalid_r, halted_r, windShort_r, curMove_r}, 0);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      req(rows[i][6:4], rows[i][7]);
      @(negedge clk_sys);
      chk("move", {acc, curMove_r}, rows[i][3:0]);
      mvDone;
    end
    $display("Test moves ended, mismatches %0d", err_count);
    u_eism_field_model.step(1'b1, 8);
    repeat (4) @(negedge clk_sys);
    chk("encFwd", encPos_r, 32'h8);
    u_eism_field_model.step(1'b0, 3);
    repeat (4) @(negedge clk_sys);
    chk("encRev", encPos_r, 32'h5);
    stallEn <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk_sys) resSel <= i[1:0];
      motorPos <= 32'h5 + (32'h80 << i);
      win(4);
      chk("stallLim", stall_r, 1'b0);
      motorPos <= 32'h6 + (32'h80 << i);
      win(4);
      chk("stallPast", {stall_r, posInvalid_r}, 2'h3);
      req(3'h4, 1'b1);
      chk("absRefused", acc, 1'b0);
      motorPos <= 32'h5;
      win(3);
      {presetReq, homeDone} <= i[0] ? 2'h1 : 2'h2;
      @(posedge clk_sys) {presetReq, homeDone} <= 2'h0;
      win(3);
      chk("cleared", {stall_r, posInvalid_r}, 2'h0);
    end
    $display("Test encoder ended, mismatches %0d", err_count);
    inFunc <= {3'h5, 3'h6, 3'h4};
    req(3'h6, 1'b1);
    win(4);
    chk("idxPend", {acc, seen[2], curMove_r}, 5'h10);
    u_eism_field_model.press(0, 1'b1);
    win(8);
    chk("idxFire", seen[3:2], 2'h3);
    chk("capVal", capPos_r, 32'h5);
    mvDone;
    u_eism_field_model.press(0, 1'b0);
    win(8);
    chk("capFall", seen[3:2], 2'h2);
    u_eism_field_model.press(1, 1'b1);
    win(8);
    chk("jsIdle", {seen[3], seen[1]}, 2'h0);
    u_eism_field_model.press(1, 1'b0);
    win(4);
    req(3'h1, 1'b1);
    u_eism_field_model.press(1, 1'b1);
    win(8);
    chk("jsJog", {seen[3], seen[1]}, 2'h3);
    mvDone;
    req(3'h2, 1'b0);
    u_eism_field_model.press(2, 1'b1);
    win(6);
    chk("haltStop", {seen[0], windShort_r}, 2'h3);
    req(3'h1, 1'b1);
    chk("haltRefuse", acc, 1'b0);
    repeat (20) @(negedge clk_sys);
    chk("haltFlag", {windShort_r, halted_r}, 2'h1);
    u_eism_field_model.press(2, 1'b0);
    win(6);
    req(3'h1, 1'b1);
    chk("afterHalt", acc, 1'b1);
    mvDone;
    inFunc[2:0] <= 3'h2;
    req(3'h1, 1'b1);
    u_eism_field_model.press(0, 1'b1);
    win(8);
    chk("limStop", seen[0], 1'b1);
    req(3'h1, 1'b1);
    chk("limSame", acc, 1'b0);
    req(3'h1, 1'b0);
    chk("limOpp", acc, 1'b1);
    mvDone;
    u_eism_field_model.press(0, 1'b0);
    {inFunc, inPol} <= 12'h1;
    win(6);
    chk("gpState", inState_r, 3'h3);
    $display("Test inputs ended, mismatches %0d", err_count);
    chk("ledOk", {ledRed_r, ledGreen_r}, 2'h1);
    overTemp <= 1'b1;
    win(3);
    chk("ledHot", {ledRed_r, ledGreen_r}, 2'h2);
    overTemp <= 1'b0;
    flashOk <= 1'b1;
    @(negedge clk_sys) flashOk <= 1'b0;
    req(3'h1, 1'b1);
    chk("flashLock", acc, 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    flashFail <= 1'b1;
    @(posedge clk_sys) flashFail <= 1'b0;
    req(3'h1, 1'b1);
    chk("failLock", acc, 1'b0);
    stallEn <= 1'b0;
    absMode <= 1'b1;
    absPos <= 32'h0012_3805;
    motorPos <= 32'h0012_3905;
    inFunc <= 9'h1;
    win(3);
    chk("absPos", encPos_r, 32'h0012_3805);
    chk("homeSeen", homeSeen, 1'b1);
    stallEn <= 1'b1;
    win(3);
    chk("absLim", stall_r, 1'b0);
    motorPos <= 32'h0012_3906;
    win(3);
    chk("absStall", stall_r, 1'b1);
    $display("Test status ended, mismatches %0d", err_count);
    tally_and_finish;
  end
endmodule // tb_top
